// ### src/range_clear_defs.vh
`ifndef RANGE_CLEAR_DEFS_VH
`define RANGE_CLEAR_DEFS_VH

// output range field encodings
`define RNG_V_0_5      3'h0
`define RNG_V_0_10     3'h1
`define RNG_V_PM5      3'h2
`define RNG_V_PM10     3'h3
`define RNG_I_4_20     3'h5
`define RNG_I_0_20     3'h6
`define RNG_I_0_24     3'h7

// dual-mode current field encodings
`define DUAL_I_4_20    2'h1
`define DUAL_I_0_20    2'h2
`define DUAL_I_0_24    2'h3

// voltage gain in tenths (1.0 = 10)
`define GAIN_X1        6'h0A
`define GAIN_X2        6'h14
`define GAIN_X4        6'h28
`define GAIN_EXT_NUM   6'h0B

// current span codes on the output port
`define ISPAN_OFF      2'h0
`define ISPAN_0_20     2'h1
`define ISPAN_0_24     2'h2
`define ISPAN_4_20     2'h3

`define DEF_WIDTH      16

`endif

// ### src/range_clear_ctrl.v
// Behaviour
// - Voltage and current outputs may both be enabled, driven by one data register.
// - Disabled outputs are high impedance; reset disables both outputs.
// - Code width is 16 or 12 bits; fraction is code over two to width.
// - Voltage range comes from range field and span extend bit.
// - Gain 1 for 0-5V, 2 for 0-10V and +-5V, 4 for +-10V.
// - Span extend bit raises voltage gain by ten percent.
// - Bipolar mode offsets by minus gain times half reference; unipolar none.
// - Current range 0-20, 0-24 or 4-20 mA, normally from range field.
// - In dual-output mode current range comes from dedicated config field.
// - 4-20 mA range adds 4 mA offset to 16 mA scaled fraction.
// - Zeroing input acts asynchronously, forcing voltage to zero-scale or to midscale (negative full-scale, code 0, when bipolar).
// - Clear level is OR of select pin and select bit.
// - During clear in single-output mode current output goes to bottom of its range.
// - After clear deasserts outputs stay at cleared value.
// - Commit strobe without new data restores the pre-clear value.
// - New output values are rejected while clear is asserted.
// - In dual mode data register clears to voltage-clear value, driving current too.
// - Clear level also sets default value loaded at reset and range change.
// - Setting the enable bit drives output to the default value.
`include "range_clear_defs.vh"

module range_clear_ctrl #(
    parameter WIDTH = `DEF_WIDTH
) (
    input wire SYS_CLK,
    input wire RST,
    input wire ASYNC_ZEROING_INPUT,
    input wire ZEROING_LEVEL_SELECT_PIN,
    input wire ZEROING_LEVEL_SELECT_BIT,
    input wire [2:0] OUTPUT_RANGE,
    input wire SPAN_EXTEND_BIT,
    input wire OUTPUT_DRIVE_ENABLE,
    input wire VOLTAGE_ENABLE,
    input wire DUAL_OUTPUT_MODE,
    input wire [1:0] DUAL_MODE_CURRENT_SPAN_FIELD,
    input wire COMMIT,
    input wire DATA_VALID,
    input wire [WIDTH-1:0] DATA_IN,
    output wire [WIDTH-1:0] OUTPUT_CODE,
    output wire VOLTAGE_OUTPUT_DRIVE,
    output wire CURRENT_OUTPUT_DRIVE,
    output wire [5:0] VOLTAGE_GAIN,
    output wire VOLTAGE_BIPOLAR,
    output wire [1:0] CURRENT_SPAN,
    output wire CLEAR_ACTIVE
);

    localparam [WIDTH-1:0] ZERO_CODE = {WIDTH{1'b0}};
    localparam [WIDTH-1:0] MID_CODE = {1'b1, {(WIDTH-1){1'b0}}};

    wire zsync_q;
    reg [WIDTH-1:0] data_q;
    reg [WIDTH-1:0] data_d;
    reg [WIDTH-1:0] preclear_q;
    reg [WIDTH-1:0] preclear_d;
    reg cleared_q;
    reg cleared_d;
    reg [2:0] range_q;
    reg enable_q;
    reg [WIDTH-1:0] out_code_q;
    reg [WIDTH-1:0] clear_code;
    reg [WIDTH-1:0] out_code_d;
    reg [5:0] gain_base;
    reg [5:0] gain_d;
    reg bipolar_d;
    reg [1:0] ispan_d;
    reg v_en_d;
    reg i_en_d;
    wire level_mid;
    wire is_current_range;
    wire range_changed;
    wire enable_rise;

    assign level_mid = ZEROING_LEVEL_SELECT_PIN | ZEROING_LEVEL_SELECT_BIT;
    assign is_current_range = OUTPUT_RANGE[2];
    assign range_changed = (OUTPUT_RANGE != range_q);
    assign enable_rise = OUTPUT_DRIVE_ENABLE & ~enable_q;

    // clear code: unipolar zero-scale is code 0; bipolar zero-scale (0 V) is midscale
    always @* begin
        clear_code = ZERO_CODE;
        case ({is_current_range & ~DUAL_OUTPUT_MODE, level_mid, bipolar_d})
            3'b000: begin
                clear_code = ZERO_CODE;
            end
            3'b001: begin
                clear_code = MID_CODE;
            end
            3'b010: begin
                clear_code = MID_CODE;
            end
            3'b011: begin
                clear_code = ZERO_CODE;
            end
            default: begin
                clear_code = ZERO_CODE;
            end
        endcase
    end

    // range decode: gain in tenths, bipolar offset flag, current span
    always @* begin
        gain_base = `GAIN_X1;
        bipolar_d = 1'b0;
        case (OUTPUT_RANGE)
            `RNG_V_0_5: begin
                gain_base = `GAIN_X1;
            end
            `RNG_V_0_10: begin
                gain_base = `GAIN_X2;
            end
            `RNG_V_PM5: begin
                gain_base = `GAIN_X2;
                bipolar_d = 1'b1;
            end
            `RNG_V_PM10: begin
                gain_base = `GAIN_X4;
                bipolar_d = 1'b1;
            end
            default: begin
                gain_base = `GAIN_X1;
            end
        endcase
        // gain tenths: x1.1 by adding one tenth of base
        if (SPAN_EXTEND_BIT) begin
            gain_d = gain_base + (gain_base / 6'h0A);
        end else begin
            gain_d = gain_base;
        end
        if (DUAL_OUTPUT_MODE) begin
            case (DUAL_MODE_CURRENT_SPAN_FIELD)
                `DUAL_I_4_20: begin
                    ispan_d = `ISPAN_4_20;
                end
                `DUAL_I_0_20: begin
                    ispan_d = `ISPAN_0_20;
                end
                `DUAL_I_0_24: begin
                    ispan_d = `ISPAN_0_24;
                end
                default: begin
                    ispan_d = `ISPAN_OFF;
                end
            endcase
        end else begin
            case (OUTPUT_RANGE)
                `RNG_I_4_20: begin
                    ispan_d = `ISPAN_4_20;
                end
                `RNG_I_0_20: begin
                    ispan_d = `ISPAN_0_20;
                end
                `RNG_I_0_24: begin
                    ispan_d = `ISPAN_0_24;
                end
                default: begin
                    ispan_d = `ISPAN_OFF;
                end
            endcase
        end
        v_en_d = OUTPUT_DRIVE_ENABLE & (DUAL_OUTPUT_MODE ? VOLTAGE_ENABLE : ~is_current_range);
        i_en_d = OUTPUT_DRIVE_ENABLE & (ispan_d != `ISPAN_OFF);
    end

    // data register update, gated by the synchronised zeroing input
    always @* begin
        data_d = data_q;
        preclear_d = preclear_q;
        cleared_d = cleared_q;
        if (zsync_q) begin
            // hold the pre-clear value once; commits ignored meanwhile
            if (!cleared_q) begin
                preclear_d = data_q;
            end
            cleared_d = 1'b1;
            data_d = clear_code;
        end else if (COMMIT && DATA_VALID) begin
            data_d = DATA_IN;
            preclear_d = DATA_IN;
            cleared_d = 1'b0;
        end else if (COMMIT && cleared_q) begin
            data_d = preclear_q;
            cleared_d = 1'b0;
        end else if (range_changed || enable_rise) begin
            data_d = clear_code;
            preclear_d = clear_code;
            cleared_d = 1'b0;
        end
    end

    // reset loads the default code of the selected clear level, not plain zero
    always @(posedge SYS_CLK) begin
        if (RST) begin
            data_q <= clear_code;
            preclear_q <= clear_code;
            cleared_q <= 1'b0;
            range_q <= `RNG_V_0_5;
            enable_q <= 1'b0;
            out_code_q <= clear_code;
        end else begin
            data_q <= data_d;
            preclear_q <= preclear_d;
            cleared_q <= cleared_d;
            range_q <= OUTPUT_RANGE;
            enable_q <= OUTPUT_DRIVE_ENABLE;
            out_code_q <= data_d;
        end
    end

    // pin may move at any time; only the second flop gates updates
    clear_sync sync_u (
        .clk(SYS_CLK),
        .rst(RST),
        .async_in(ASYNC_ZEROING_INPUT),
        .sync_q(zsync_q)
    );

    reset_reg #(
        .W(1),
        .INIT(1'b0)
    ) v_drive_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(v_en_d),
        .q(VOLTAGE_OUTPUT_DRIVE)
    );

    reset_reg #(
        .W(1),
        .INIT(1'b0)
    ) i_drive_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(i_en_d),
        .q(CURRENT_OUTPUT_DRIVE)
    );

    reset_reg #(
        .W(6),
        .INIT(`GAIN_X1)
    ) gain_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(gain_d),
        .q(VOLTAGE_GAIN)
    );

    reset_reg #(
        .W(1),
        .INIT(1'b0)
    ) bipolar_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(bipolar_d),
        .q(VOLTAGE_BIPOLAR)
    );

    reset_reg #(
        .W(2),
        .INIT(`ISPAN_OFF)
    ) span_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(ispan_d),
        .q(CURRENT_SPAN)
    );

    reset_reg #(
        .W(1),
        .INIT(1'b0)
    ) clear_flag_u (
        .clk(SYS_CLK),
        .rst(RST),
        .d(zsync_q),
        .q(CLEAR_ACTIVE)
    );

    // output code bypasses the synchroniser so clear takes effect without a clock
    always @* begin
        out_code_d = out_code_q;
        if (ASYNC_ZEROING_INPUT) begin
            out_code_d = clear_code;
        end
    end

    assign OUTPUT_CODE = out_code_d;

endmodule

module clear_sync (
    input wire clk,
    input wire rst,
    input wire async_in,
    output reg sync_q
);

    reg meta_q;

    // meta_q may be metastable, so nothing else reads it
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule

module reset_reg #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    always @(posedge clk) begin
        if (rst) begin
            q <= INIT;
        end else begin
            q <= d;
        end
    end

endmodule

// ### bench/range_clear_ctrl_asserts.sv
module range_clear_ctrl_asserts #(parameter WIDTH = 16) (
    input logic SYS_CLK, RST, ASYNC_ZEROING_INPUT, SPAN_EXTEND_BIT, DUAL_OUTPUT_MODE,
    input logic ZEROING_LEVEL_SELECT_PIN, ZEROING_LEVEL_SELECT_BIT, COMMIT, DATA_VALID,
    input logic VOLTAGE_OUTPUT_DRIVE, CURRENT_OUTPUT_DRIVE, VOLTAGE_BIPOLAR, CLEAR_ACTIVE,
    input logic [2:0] OUTPUT_RANGE,
    input logic [1:0] DUAL_MODE_CURRENT_SPAN_FIELD, CURRENT_SPAN,
    input logic [5:0] VOLTAGE_GAIN,
    input logic [WIDTH-1:0] DATA_IN, OUTPUT_CODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire lvl = ZEROING_LEVEL_SELECT_PIN | ZEROING_LEVEL_SELECT_BIT;
    chk_reset_off: assert property (disable iff (1'b0) RST |=>
        !VOLTAGE_OUTPUT_DRIVE && !CURRENT_OUTPUT_DRIVE && VOLTAGE_GAIN == 6'h0A)
        else $error("outputs on after reset");
    chk_gain_map: assert property (OUTPUT_RANGE == 3'h3 && !SPAN_EXTEND_BIT |=>
        VOLTAGE_GAIN == 6'h28) else $error("wrong gain");
    chk_gain_extend: assert property (OUTPUT_RANGE == 3'h1 && SPAN_EXTEND_BIT |=>
        VOLTAGE_GAIN == 6'h16) else $error("wrong extended gain");
    chk_bipolar_mode: assert property (1'b1 |=>
        VOLTAGE_BIPOLAR == ($past(OUTPUT_RANGE) inside {3'h2, 3'h3})) else $error("bad offset");
    chk_span_normal: assert property (!DUAL_OUTPUT_MODE && OUTPUT_RANGE == 3'h5 |=>
        CURRENT_SPAN == 2'h3) else $error("wrong current span");
    chk_span_dual: assert property (DUAL_OUTPUT_MODE && DUAL_MODE_CURRENT_SPAN_FIELD == 2'h2
        |=> CURRENT_SPAN == 2'h1) else $error("wrong dual span");
    chk_clear_level: assert property (ASYNC_ZEROING_INPUT && OUTPUT_RANGE == 3'h0 &&
        $stable(OUTPUT_RANGE) && $stable(lvl) |-> OUTPUT_CODE == (lvl ? 1 << (WIDTH - 1) : 0))
        else $error("wrong clear code");
    chk_clear_sync: assert property ($rose(ASYNC_ZEROING_INPUT) |-> ##[1:3] CLEAR_ACTIVE)
        else $error("clear not seen");
    chk_commit_load: assert property (COMMIT && DATA_VALID && !CLEAR_ACTIVE &&
        !ASYNC_ZEROING_INPUT && $stable(OUTPUT_RANGE) |=> ASYNC_ZEROING_INPUT ||
        OUTPUT_CODE == $past(DATA_IN)) else $error("commit not loaded");
endmodule

bind range_clear_ctrl range_clear_ctrl_asserts #(.WIDTH(WIDTH)) chk_u (.*);

// ### bench/range_clear_host.sv
module range_clear_host (
    input wire logic SYS_CLK,
    input wire logic ASYNC_ZEROING_INPUT,
    output logic COMMIT,
    output logic DATA_VALID,
    output logic [15:0] DATA_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {COMMIT, DATA_VALID, DATA_IN} = '0;
    // push_on breaks the wait on purpose, to show the refusal
    task automatic send(input logic dv, input logic [15:0] d, input logic push_on);
        int n;
        n = 0;
        while (ASYNC_ZEROING_INPUT && !push_on && n < 50) begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n >= 50) range_clear_ctrl_tb_top.fail_count++;
        @(posedge SYS_CLK) #1;
        {COMMIT, DATA_VALID, DATA_IN} = {1'b1, dv, d};
        @(posedge SYS_CLK) #1;
        {COMMIT, DATA_VALID, DATA_IN} = {2'b00, ~d}; // released bus keeps no stale value
    endtask
endmodule

// ### bench/range_clear_ctrl_tb_top.sv
module range_clear_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK, RST, ASYNC_ZEROING_INPUT, ZEROING_LEVEL_SELECT_PIN, ZEROING_LEVEL_SELECT_BIT;
    logic SPAN_EXTEND_BIT, OUTPUT_DRIVE_ENABLE, VOLTAGE_ENABLE, DUAL_OUTPUT_MODE, COMMIT;
    logic DATA_VALID, VOLTAGE_OUTPUT_DRIVE, CURRENT_OUTPUT_DRIVE, VOLTAGE_BIPOLAR, CLEAR_ACTIVE;
    logic [2:0] OUTPUT_RANGE;
    logic [1:0] DUAL_MODE_CURRENT_SPAN_FIELD, CURRENT_SPAN;
    logic [5:0] VOLTAGE_GAIN;
    logic [15:0] DATA_IN, OUTPUT_CODE;
    int fail_count = 0;
    int num_checks = 0;
    range_clear_ctrl #(.WIDTH(16)) dut_u (.*);
    range_clear_host host_u (.*);
    initial begin
        SYS_CLK = 0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic wait_clear(input logic lvl);
        for (int n = 0; CLEAR_ACTIVE !== lvl; n++) begin
            if (n > 8) begin
                fail_count++;
                complete_run();
            end
            tick(1);
        end
    endtask
    task automatic t_ranges();
        logic [5:0] g[4] = '{6'h0A, 6'h14, 6'h14, 6'h28};
        for (int e = 0; e < 8; e++) begin
            {SPAN_EXTEND_BIT, OUTPUT_RANGE} = {e[2], 1'b0, e[1:0]};
            tick(2);
            chk(VOLTAGE_GAIN, e[2] ? g[e[1:0]] + g[e[1:0]] / 10 : g[e[1:0]]);
            chk(VOLTAGE_BIPOLAR, e[1]);
        end
        for (int r = 5; r < 8; r++) begin
            OUTPUT_RANGE = r;
            tick(2);
            chk(CURRENT_SPAN, r == 5 ? 3 : r - 5);
        end
        {DUAL_OUTPUT_MODE, VOLTAGE_ENABLE} = 2'b11;
        for (int f = 1; f < 4; f++) begin
            DUAL_MODE_CURRENT_SPAN_FIELD = f;
            tick(2);
            chk(CURRENT_SPAN, f == 1 ? 3 : f - 1);
        end
    endtask
    task automatic t_clear();
        {DUAL_OUTPUT_MODE, VOLTAGE_ENABLE, OUTPUT_RANGE} = '0;
        tick(2);
        OUTPUT_DRIVE_ENABLE = 1;
        tick(2);
        chk(VOLTAGE_OUTPUT_DRIVE, 1);
        chk(OUTPUT_CODE, 0);
        host_u.send(1, 16'h1234, 0);
        chk(OUTPUT_CODE, 16'h1234);
        {ZEROING_LEVEL_SELECT_BIT, ASYNC_ZEROING_INPUT} = 2'b11;
        #1 chk(OUTPUT_CODE, 16'h8000);
        wait_clear(1);
        host_u.send(1, 16'h5555, 1);
        chk(OUTPUT_CODE, 16'h8000);
        ASYNC_ZEROING_INPUT = 0;
        wait_clear(0);
        chk(OUTPUT_CODE, 16'h8000);
        host_u.send(0, 16'h0000, 0);
        chk(OUTPUT_CODE, 16'h1234);
        {ZEROING_LEVEL_SELECT_BIT, ZEROING_LEVEL_SELECT_PIN} = 2'b01;
        {OUTPUT_DRIVE_ENABLE, OUTPUT_RANGE} = {1'b0, 3'h2};
        tick(3);
        chk(OUTPUT_CODE, 0);
        {DUAL_OUTPUT_MODE, VOLTAGE_ENABLE, DUAL_MODE_CURRENT_SPAN_FIELD} = 4'hD;
        OUTPUT_DRIVE_ENABLE = 1;
        tick(2);
        chk(VOLTAGE_OUTPUT_DRIVE, 1);
        chk(CURRENT_OUTPUT_DRIVE, 1);
        host_u.send(1, 16'h4321, 0);
        chk(OUTPUT_CODE, 16'h4321);
        {ZEROING_LEVEL_SELECT_PIN, ASYNC_ZEROING_INPUT} = 2'b01;
        #1 chk(OUTPUT_CODE, 16'h8000);
        tick(1);
        {DUAL_OUTPUT_MODE, OUTPUT_RANGE} = {1'b0, 3'h5};
        #1 chk(OUTPUT_CODE, 16'h0000);
        wait_clear(1);
        ASYNC_ZEROING_INPUT = 0;
        wait_clear(0);
        chk(OUTPUT_CODE, 16'h0000);
    endtask
    initial begin
        {ASYNC_ZEROING_INPUT, ZEROING_LEVEL_SELECT_PIN, ZEROING_LEVEL_SELECT_BIT} = '0;
        {SPAN_EXTEND_BIT, OUTPUT_DRIVE_ENABLE, VOLTAGE_ENABLE, DUAL_OUTPUT_MODE} = '0;
        {OUTPUT_RANGE, DUAL_MODE_CURRENT_SPAN_FIELD} = '0;
        RST = 1;
        tick(20);
        chk(CURRENT_OUTPUT_DRIVE, 0);
        RST = 0;
        tick(2);
        chk(OUTPUT_CODE, 0);
        t_ranges();
        t_clear();
        complete_run();
    end
endmodule
